// file: rtl/hppm_keeper.sv
// Purpose: Bus keeper state for the eight host port data pins.
// Assumes: pin_i is the resolved wire level, keeper included.
// Notes: Outputs a weak hold level and its enable for the pad model.
`timescale 1ns/1ps

module hppm_keeper (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Next drive state of the pins
    input wire logic [hppm_pkg::DATA_W-1:0] oe_d,
    input wire logic [hppm_pkg::DATA_W-1:0] o_d,
    input wire logic [hppm_pkg::DATA_W-1:0] pin_i,
    input wire logic en_d,
    // Weak hold level per pin
    output logic [hppm_pkg::DATA_W-1:0] keep_val_q,
    output logic [hppm_pkg::DATA_W-1:0] keep_act_q
);
    import hppm_pkg::*;

    // =========================================================
    // Hold level tracking
    // =========================================================
    // While driven the pin's own value is kept, else the wire's level,
    // so a float inherits the level that was last on the wire.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            keep_val_q <= DATA_RST;
        end else begin
            keep_val_q <= (oe_d & o_d) | (~oe_d & pin_i);
        end
    end

    // Keepers are active from reset; afterwards software decides for undriven pins, and a driven pin never keeps.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            keep_act_q <= {DATA_W{KEEP_ACT_RST}};
        end else begin
            keep_act_q <= {DATA_W{en_d}} & ~oe_d;
        end
    end

    // =========================================================
    // Checks
    // =========================================================
    // The release edge itself still leaves reset values behind, so an
    // attempt only counts when reset was already high as it started.
    keep_track_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        rst_n |=> keep_val_q == (($past(oe_d) & $past(o_d)) |
            (~$past(oe_d) & $past(pin_i))))
        else $error("keeper lost the last driven level");

endmodule : hppm_keeper

// file: rtl/hppm_pkg.sv
// Purpose: Constants and types for the host port pin mux.
// Assumes: One clock, 25 MHz; no software-visible registers in this block.
// Notes: Shared by the top module and the bus keeper.
package hppm_pkg;

    // =========================================================
    // Widths and bit numbering
    // =========================================================
    localparam int DATA_W = 8;
    // Parallel I/O numbering carried by the data pins and control pin.
    localparam int PIO_UPPER_LSB = 36;
    localparam int PIO_UPPER_MSB = 43;
    localparam int PIO_CTRL_BIT = 44;

    // =========================================================
    // Reset values
    // =========================================================
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic OE_RST = 1'b0;
    localparam logic KEEP_ACT_RST = 1'b1;
    localparam logic BIT_RST = 1'b0;

    // =========================================================
    // Types
    // =========================================================
    typedef enum logic {HPPM_FUNC_GPIO, HPPM_FUNC_HOST} hppm_func_t;
    typedef enum logic {HPPM_BYTE_FIRST, HPPM_BYTE_SECOND} hppm_byte_t;

endpackage : hppm_pkg

// file: rtl/hppm_top.sv
// Purpose: Pin mux for the host port data pins and control pin zero.
// Assumes: Pin inputs are synchronous to SYS_CLK; the GPIO and host
//          interface logic sit outside and drive the user-side ports.
// Notes: The function select is captured on every rising edge while reset is
//        held and frozen at release.
`timescale 1ns/1ps

module hppm_top (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    // Function select strap
    input wire logic FUNC_SEL_PIN,
    // Host port data pins
    input wire logic [hppm_pkg::DATA_W-1:0] HOST_PORT_DATA_PINS_I,
    output logic [hppm_pkg::DATA_W-1:0] HOST_PORT_DATA_PINS_O,
    output logic [hppm_pkg::DATA_W-1:0] HOST_PORT_DATA_PINS_OE,
    output logic [hppm_pkg::DATA_W-1:0] HOST_PORT_DATA_KEEP,
    output logic [hppm_pkg::DATA_W-1:0] HOST_PORT_DATA_KEEP_EN,
    // Host control pin zero
    input wire logic HOST_CTRL_ZERO_I,
    output logic HOST_CTRL_ZERO_O,
    output logic HOST_CTRL_ZERO_OE,
    // Keeper enable bit of the external bus control register
    input wire logic KEEPER_EN,
    // Parallel I/O upper byte and bit forty-four
    output logic [hppm_pkg::DATA_W-1:0] PIO_UPPER_IN,
    input wire logic [hppm_pkg::DATA_W-1:0] PIO_UPPER_OUT,
    input wire logic [hppm_pkg::DATA_W-1:0] PIO_UPPER_DIR,
    output logic PIO_BIT44_IN,
    input wire logic PIO_BIT44_OUT,
    input wire logic PIO_BIT44_DIR,
    // Host interface side
    output logic [hppm_pkg::DATA_W-1:0] HOST_IFACE_DATA_IN,
    input wire logic [hppm_pkg::DATA_W-1:0] HOST_IFACE_DATA_OUT,
    input wire logic [hppm_pkg::DATA_W-1:0] HOST_IFACE_DATA_OE,
    output logic HOST_ADDR_STROBE,
    input wire logic HOST_XFER_STB,
    output logic HOST_SECOND_BYTE,
    output logic HOST_PAIR_DONE,
    // Sampled function
    output logic FUNC_IS_HOST
);
    import hppm_pkg::*;

    // =========================================================
    // Declarations
    // =========================================================
    logic rst_meta_q;
    logic rst_n_q;
    hppm_func_t func_q;
    logic host_mode;
    hppm_byte_t phase_q;
    logic [DATA_W-1:0] data_o_d;
    logic [DATA_W-1:0] data_oe_d;

    // Select between the host bus value and the GPIO value.
    function automatic logic [DATA_W-1:0] pick8(
        input logic host,
        input logic [DATA_W-1:0] host_v,
        input logic [DATA_W-1:0] gpio_v
    );
        pick8 = host ? host_v : gpio_v;
    endfunction : pick8

    // =========================================================
    // Reset release
    // =========================================================
    // Two flops so that release is clean relative to SYS_CLK.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // =========================================================
    // Function select capture
    // =========================================================
    // No async reset here: the strap must be taken from the pin, which
    // an async reset may not do. The last capture before release stays.
    always_ff @(posedge SYS_CLK) begin
        if (!rst_n_q) begin
            func_q <= FUNC_SEL_PIN ? HPPM_FUNC_HOST : HPPM_FUNC_GPIO;
        end
    end
    // Nothing else writes func_q, so it holds until next reset.
    assign host_mode = (func_q == HPPM_FUNC_HOST);

    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            FUNC_IS_HOST <= BIT_RST;
        end else begin
            FUNC_IS_HOST <= host_mode;
        end
    end

    // =========================================================
    // Data pin drive
    // =========================================================
    // Both functions share one set of pads; the other side's drive is
    // ignored entirely, so a stray GPIO direction cannot fight the host.
    assign data_o_d = pick8(host_mode, HOST_IFACE_DATA_OUT, PIO_UPPER_OUT);
    assign data_oe_d = rst_n_q ?
        pick8(host_mode, HOST_IFACE_DATA_OE, PIO_UPPER_DIR) :
        {DATA_W{OE_RST}};

    // Enables reset low: inputs in either function after reset.
    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            HOST_PORT_DATA_PINS_O <= DATA_RST;
            HOST_PORT_DATA_PINS_OE <= {DATA_W{OE_RST}};
        end else begin
            HOST_PORT_DATA_PINS_O <= data_o_d;
            HOST_PORT_DATA_PINS_OE <= data_oe_d;
        end
    end

    // Incoming pin levels go to whichever function owns the pads.
    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            PIO_UPPER_IN <= DATA_RST;
            HOST_IFACE_DATA_IN <= DATA_RST;
        end else begin
            PIO_UPPER_IN <= host_mode ? DATA_RST : HOST_PORT_DATA_PINS_I;
            HOST_IFACE_DATA_IN <= host_mode ? HOST_PORT_DATA_PINS_I :
                DATA_RST;
        end
    end

    // =========================================================
    // Control pin zero
    // =========================================================
    // As a strobe the pin is input only; as a GPIO it follows direction.
    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            HOST_CTRL_ZERO_O <= BIT_RST;
            HOST_CTRL_ZERO_OE <= OE_RST;
            PIO_BIT44_IN <= BIT_RST;
            HOST_ADDR_STROBE <= BIT_RST;
        end else begin
            HOST_CTRL_ZERO_O <= host_mode ? BIT_RST : PIO_BIT44_OUT;
            HOST_CTRL_ZERO_OE <= host_mode ? OE_RST : PIO_BIT44_DIR;
            PIO_BIT44_IN <= host_mode ? BIT_RST : HOST_CTRL_ZERO_I;
            // Strobe exists only in host mode.
            HOST_ADDR_STROBE <= host_mode ? HOST_CTRL_ZERO_I : BIT_RST;
        end
    end

    // =========================================================
    // Byte pairing
    // =========================================================
    // Every host cycle is two transfers; an odd first byte simply waits
    // for its partner, as phase_q alone tracks which byte is which.
    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            phase_q <= HPPM_BYTE_FIRST;
            HOST_SECOND_BYTE <= BIT_RST;
            HOST_PAIR_DONE <= BIT_RST;
        end else begin
            HOST_PAIR_DONE <= BIT_RST;
            if (host_mode && HOST_XFER_STB) begin
                case (phase_q)
                    HPPM_BYTE_FIRST: begin
                        phase_q <= HPPM_BYTE_SECOND;
                        HOST_SECOND_BYTE <= 1'h1;
                    end
                    default: begin
                        phase_q <= HPPM_BYTE_FIRST;
                        HOST_SECOND_BYTE <= BIT_RST;
                        HOST_PAIR_DONE <= 1'h1;
                    end
                endcase
            end
        end
    end
    // The second-byte flag is its own flop so the port is registered.

    // =========================================================
    // Bus keepers
    // =========================================================
    hppm_keeper u_keeper (
        .clk(SYS_CLK),
        .rst_n(rst_n_q),
        .oe_d(data_oe_d),
        .o_d(data_o_d),
        .pin_i(HOST_PORT_DATA_PINS_I),
        .en_d(KEEPER_EN),
        .keep_val_q(HOST_PORT_DATA_KEEP),
        .keep_act_q(HOST_PORT_DATA_KEEP_EN)
    );

    // =========================================================
    // Checks
    // =========================================================
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!rst_n_q);

    sequence first_byte_s;
        host_mode && HOST_XFER_STB && !HOST_SECOND_BYTE;
    endsequence
    sequence second_byte_s;
        host_mode && HOST_XFER_STB && HOST_SECOND_BYTE;
    endsequence

    // The release edge still loads reset values, so routing checks only
    // start attempts once the internal reset was already high.
    sel_frozen_a: assert property ($past(rst_n_q) |-> $stable(func_q))
        else $error("function select changed after release");
    gpio_route_a: assert property (
        rst_n_q && !host_mode |=>
            PIO_UPPER_IN == $past(HOST_PORT_DATA_PINS_I))
        else $error("data pins not routed to GPIO");
    host_route_a: assert property (
        rst_n_q && host_mode |=>
            HOST_IFACE_DATA_IN == $past(HOST_PORT_DATA_PINS_I)
            && PIO_UPPER_IN == DATA_RST)
        else $error("data pins not routed to host bus");
    host_undriven_a: assert property (
        host_mode && (HOST_IFACE_DATA_OE == '0) |=>
            HOST_PORT_DATA_PINS_OE == '0)
        else $error("host data pins driven without request");
    gpio_input_a: assert property (
        !host_mode && (PIO_UPPER_DIR == '0) |=>
            HOST_PORT_DATA_PINS_OE == '0)
        else $error("GPIO bits driven while inputs");
    strobe_route_a: assert property (
        rst_n_q && host_mode |=>
            HOST_ADDR_STROBE == $past(HOST_CTRL_ZERO_I)
            && !HOST_CTRL_ZERO_OE)
        else $error("control pin zero not routed to strobe");
    bit44_route_a: assert property (
        rst_n_q && !host_mode |=>
            PIO_BIT44_IN == $past(HOST_CTRL_ZERO_I)
            && HOST_CTRL_ZERO_OE == $past(PIO_BIT44_DIR))
        else $error("control pin zero not routed to GPIO");
    keeper_off_a: assert property (
        rst_n_q && !KEEPER_EN |=> HOST_PORT_DATA_KEEP_EN == '0)
        else $error("keeper active while disabled");
    pair_seq_a: assert property (
        first_byte_s |=> HOST_SECOND_BYTE && !HOST_PAIR_DONE)
        else $error("first byte did not open the pair");
    pair_done_a: assert property (
        second_byte_s |=> HOST_PAIR_DONE && !HOST_SECOND_BYTE ##1
            !HOST_PAIR_DONE)
        else $error("second byte did not close the pair");

endmodule : hppm_top

// file: tb/hppm_host.sv
// Purpose: Behavioural host processor on the far side of the host port.
// Assumes: Its tasks are called just after a falling clock edge.
// Notes: Released data lines show the inverse of the last byte.
`timescale 1ns/1ps

module hppm_host (
    // Clock
    input wire logic clk,
    // Lines toward the device
    output logic [7:0] ext_d,
    output logic ext_oe,
    output logic strobe_n,
    output logic byte_id
);
    // ==========================================================
    // Host cycle bytes
    // ==========================================================
    // Start released with the strobe idle.
    initial begin
        ext_d = 8'h00;
        ext_oe = 1'b0;
        strobe_n = 1'b1;
        byte_id = 1'b0;
    end

    // The strobe goes low only with the address byte of a pair.
    task automatic put_byte(input logic [7:0] v, input logic second);
        ext_d = v;
        ext_oe = 1'b1;
        byte_id = second;
        strobe_n = second;
    endtask : put_byte

    // Floating lines never echo the old byte, so a stale read shows.
    task automatic release_bus;
        ext_oe = 1'b0;
        ext_d = ~ext_d;
        strobe_n = 1'b1;
    endtask : release_bus
endmodule : hppm_host

// file: tb/tb_hppm_top.sv
// Purpose: Self-checking bench for the host port pin mux.
// Assumes: Inputs change at the falling edge; results one edge later.
// Notes: Notes queued with a change are checked after the next edge.
`timescale 1ns/1ps

module tb_hppm_top;
    import hppm_pkg::*;
    typedef struct {int id; logic [7:0] exp;} hppm_note_t;
    logic sys_clk, arst_n, fsel, ken, ci, xstb, p44o, p44d, co, coe;
    logic p44i, astb, sec, pdone, ishost, eoe, stn, bid;
    logic [DATA_W-1:0] pi, po, poe, kp, ke, pin, pout, pdir, hin, hout, hoe;
    logic [7:0] ed, v;
    int err_total = 0;
    int num_checks = 0;
    hppm_note_t notes[$];
    string nm[12] = '{"PINS_O", "PINS_OE", "KEEP", "KEEP_EN", "PIO_IN",
        "HIF_IN", "PIO44_IN", "ADDR_STB", "SECOND", "PAIR_DONE", "IS_HOST",
        "CTRL"};

    hppm_top i_hppm_top (.SYS_CLK(sys_clk), .ARST_N(arst_n),
        .FUNC_SEL_PIN(fsel), .HOST_PORT_DATA_PINS_I(pi),
        .HOST_PORT_DATA_PINS_O(po), .HOST_PORT_DATA_PINS_OE(poe),
        .HOST_PORT_DATA_KEEP(kp), .HOST_PORT_DATA_KEEP_EN(ke),
        .HOST_CTRL_ZERO_I(ci), .HOST_CTRL_ZERO_O(co),
        .HOST_CTRL_ZERO_OE(coe), .KEEPER_EN(ken), .PIO_UPPER_IN(pin),
        .PIO_UPPER_OUT(pout), .PIO_UPPER_DIR(pdir), .PIO_BIT44_IN(p44i),
        .PIO_BIT44_OUT(p44o), .PIO_BIT44_DIR(p44d), .HOST_IFACE_DATA_IN(hin),
        .HOST_IFACE_DATA_OUT(hout), .HOST_IFACE_DATA_OE(hoe),
        .HOST_ADDR_STROBE(astb), .HOST_XFER_STB(xstb),
        .HOST_SECOND_BYTE(sec), .HOST_PAIR_DONE(pdone),
        .FUNC_IS_HOST(ishost));
    hppm_host i_hppm_host (.clk(sys_clk), .ext_d(ed), .ext_oe(eoe),
        .strobe_n(stn), .byte_id(bid));

    // ==========================================================
    // Pads and scoreboard
    // ==========================================================
    // Pad level: device drive, then host, then keeper, else floating.
    always_comb begin
        for (int b = 0; b < DATA_W; b++) begin
            if (poe[b]) pi[b] = po[b];
            else if (eoe) pi[b] = ed[b];
            else if (ke[b]) pi[b] = kp[b];
            else pi[b] = ~kp[b];
        end
        ci = coe ? co : stn;
    end

    function automatic logic [7:0] seen(input int id);
        case (id)
            0: seen = po;
            1: seen = poe;
            2: seen = kp;
            3: seen = ke;
            4: seen = pin;
            5: seen = hin;
            6: seen = {7'h00, p44i};
            7: seen = {7'h00, astb};
            8: seen = {7'h00, sec};
            9: seen = {7'h00, pdone};
            10: seen = {7'h00, ishost};
            default: seen = {6'h00, coe, co};
        endcase
    endfunction : seen

    task automatic check(input string w, input logic [7:0] g, e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask : check

    task automatic note(input int id, input logic [7:0] e);
        notes.push_back('{id, e});
    endtask : note

    // Settled outputs are compared a few ns after each rising edge.
    always @(posedge sys_clk) begin
        hppm_note_t n;
        #5;
        while (notes.size() > 0) begin
            n = notes.pop_front();
            check(nm[n.id], seen(n.id), n.exp);
        end
    end

    task automatic do_reset(input logic sel);
        arst_n = 1'b0;
        fsel = sel;
        ken = 1'b1;
        repeat (5) @(negedge sys_clk);
        note(1, 8'h00);
        note(3, 8'hff);
        arst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
    endtask : do_reset

    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done

    // ==========================================================
    // Stimulus
    // ==========================================================
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // A hang is cut short far beyond the expected run length.
    initial begin
        repeat (3000) @(posedge sys_clk);
        err_total++;
        test_done();
    end

    initial begin
        {xstb, p44o, p44d, pout, pdir, hout, hoe} = '0;
        void'($urandom(83));
        do_reset(1'b0);
        note(10, 8'h00);
        note(1, 8'h00);
        note(3, 8'hff);
        fsel = 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(negedge sys_clk);
            v = 8'($urandom);
            {pout, pdir, hout, hoe} = {v, 8'hff, ~v, 8'hff};
            {p44o, p44d} = {v[0], 1'b1};
            note(0, v);
            note(1, 8'hff);
            note(3, 8'h00);
            note(11, {7'h01, v[0]});
            note(10, 8'h00);
            @(negedge sys_clk);
            {pdir, hoe, p44d, xstb} = {8'h00, 8'h00, 1'b0, 1'b1};
            i_hppm_host.put_byte(~v, i[0]);
            note(4, v);
            note(6, {7'h00, v[0]});
            note(9, 8'h00);
            @(negedge sys_clk);
            ken = v[1];
            xstb = 1'b0;
            note(4, ~v);
            note(5, 8'h00);
            note(6, {7'h00, i[0]});
            note(7, 8'h00);
            note(3, {8{v[1]}});
            note(9, 8'h00);
            @(negedge sys_clk);
            i_hppm_host.release_bus();
        end
        do_reset(1'b1);
        note(10, 8'h01);
        note(1, 8'h00);
        note(3, 8'hff);
        fsel = 1'b0;
        for (int i = 0; i < 3; i++) begin
            @(negedge sys_clk);
            v = 8'($urandom);
            xstb = 1'b1;
            i_hppm_host.put_byte(v, 1'b0);
            note(5, v);
            note(4, 8'h00);
            note(7, 8'h00);
            note(8, {7'h00, !bid});
            note(10, 8'h01);
            @(negedge sys_clk);
            i_hppm_host.put_byte(~v, 1'b1);
            note(5, ~v);
            note(7, 8'h01);
            note(8, 8'h00);
            note(9, 8'h01);
            @(negedge sys_clk);
            xstb = 1'b0;
            i_hppm_host.release_bus();
            note(9, 8'h00);
        end
        @(negedge sys_clk);
        {hout, hoe, ken} = {v, 8'hff, 1'b1};
        note(0, v);
        note(1, 8'hff);
        @(negedge sys_clk);
        hoe = 8'h00;
        note(3, 8'hff);
        @(negedge sys_clk);
        note(2, v);
        note(5, v);
        repeat (2) @(negedge sys_clk);
        test_done();
    end
endmodule : tb_hppm_top
